// file: core/byte_fifo.sv
// holds a small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic in_valid, // write side offers a word
  output logic in_ready, // fifo has room
  input wire logic [WIDTH-1:0] in_data, // word written
  output logic out_valid, // fifo holds a word
  input wire logic out_ready, // read side takes the word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr_q + 1'b1);
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr_q + 1'b1);
      end
      if (push && !pop)
      begin
        count_q <= (AW+1)'(count_q + 1'b1);
      end
      else if (pop && !push)
      begin
        count_q <= (AW+1)'(count_q - 1'b1);
      end
    end
  end
endmodule // byte_fifo

// file: core/uart_char_tx.sv
// holds the 11-bit character transmitter: start, 8 data lsb first, odd parity, stop
// assumes bit_period is stable while a character is in flight
`timescale 1ns/1ps
module uart_char_tx (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [uart_slave_pkg::BIT_CNT_W-1:0] bit_period, // clocks per bit
  input wire logic enable, // may start a new character
  input wire logic in_valid, // byte offered
  output logic in_ready, // byte taken this cycle when valid
  input wire logic [7:0] in_data, // byte to send
  output logic tx_out, // serial line, idle high
  output logic busy // character in flight
);
  logic [9:0] sh_q;
  logic [uart_slave_pkg::BIT_CNT_W-1:0] cnt_q;
  logic [3:0] idx_q;
  logic busy_q;
  logic tx_q;

  assign in_ready = !busy_q && enable;
  assign busy = busy_q;
  assign tx_out = tx_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sh_q <= '1;
      cnt_q <= '0;
      idx_q <= uart_slave_pkg::CHAR_START_IDX;
      busy_q <= 1'b0;
      tx_q <= 1'b1;
    end
    else if (!busy_q)
    begin
      if (in_valid && enable)
      begin
        tx_q <= 1'b0;
        sh_q <= {1'b1, ~^in_data, in_data};
        cnt_q <= bit_period - 1'b1;
        idx_q <= uart_slave_pkg::CHAR_START_IDX;
        busy_q <= 1'b1;
      end
    end
    else if (cnt_q == '0)
    begin
      if (idx_q == uart_slave_pkg::CHAR_STOP_IDX)
      begin
        busy_q <= 1'b0;
        tx_q <= 1'b1;
      end
      else
      begin
        tx_q <= sh_q[0];
        sh_q <= {1'b1, sh_q[9:1]};
        idx_q <= idx_q + 1'b1;
        cnt_q <= bit_period - 1'b1;
      end
    end
    else
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // uart_char_tx

// file: core/uart_register_access_slave.sv
// holds the serial register access slave: autobaud receiver, frame checker,
// register request port and reply sequencer feeding a 4-byte fifo and transmitter
// assumes rx_in is synchronous to sys_clk and registers answer one cycle after a read
//
// Functional notes
// - half-duplex: transmitting only starts while no character is being received
// - character: low start, eight data, odd parity, high stop; eleven bits
// - data bits go least significant first both ways
// - bit period measured automatically; 1200 to 19200 baud work unconfigured
// - chip reset or software reset returns the interface to idle
// - order: header, control, address, data0..data3 low first, check byte
// - read/write commands get a reply; broadcast gets none
// - over 20 ms between received bytes discards the partial frame
// - reply begins between 1 ms and 20 ms after command end
// - gap between reply characters never exceeds 20 ms
// - valid write stores the word and answers with four bytes
// - read/write accepted only when control bits 3:2 equal address pins
// - each bit lasts one measured bit period, eleven per character
// - check byte is inverted byte sum plus 0x33; same for replies
// - control bits 1:0 select op; bits 7:4 high address nibble
// - read count zero means one; reply header, control, length, data, check
`timescale 1ns/1ps
module uart_register_access_slave #(
  parameter int RX_TIMEOUT_CYC = uart_slave_pkg::RX_INTERBYTE_TIMEOUT_CYC,
  parameter int REPLY_DELAY_CYC = uart_slave_pkg::REPLY_TURNAROUND_DELAY_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic sys_clk, // system clock, 40 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic sw_reset, // software reset request, active high
  input wire logic rx_in, // serial line from host, idle high
  input wire logic chip_addr_pin_hi, // chip select strap, compared with control bit 3
  input wire logic chip_addr_pin_lo, // chip select strap, compared with control bit 2
  input wire logic [31:0] reg_rdata, // register data, valid the cycle after a read pulse
  output logic tx_out, // serial line to host, idle high
  output uart_slave_pkg::reg_req_t reg_req_q // register write/read request pulses
);

  // ***********************************************
  // types and signals
  // ***********************************************
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_MEAS = 3'b010,
    RX_BITS = 3'b100
  } rx_state_t;

  typedef enum logic [10:0] {
    SQ_IDLE = 11'h001,
    SQ_DELAY = 11'h002,
    SQ_HEAD = 11'h004,
    SQ_CTRL = 11'h008,
    SQ_THIRD = 11'h010,
    SQ_RD = 11'h020,
    SQ_RDW = 11'h040,
    SQ_RDL = 11'h080,
    SQ_DATA = 11'h100,
    SQ_SUM = 11'h200,
    SQ_DRAIN = 11'h400
  } seq_state_t;

  localparam int BW = uart_slave_pkg::BIT_CNT_W;
  localparam int GW = uart_slave_pkg::GAP_CNT_W;

  logic rst_all;
  logic rx_prev_q;
  rx_state_t rx_st_q;
  logic [BW-1:0] bit_per_q;
  logic [BW-1:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [8:0] rx_sh_q;
  logic byte_stb_q;
  logic byte_ok_q;
  logic [7:0] byte_q;
  logic [3:0] frame_cnt_q;
  uart_slave_pkg::cmd_t cmd_q;
  logic [7:0] sum_q;
  logic [GW-1:0] gap_q;
  logic cmd_go_q;
  seq_state_t sq_q;
  logic [GW-1:0] dly_q;
  logic [7:0] words_q;
  logic [11:0] rd_addr_q;
  logic [31:0] rdbuf_q;
  logic [1:0] bytes_q;
  logic [7:0] tsum_q;
  logic is_read_q;
  logic push_valid;
  logic [7:0] push_data;
  logic push_ready;
  logic fifo_valid;
  logic fifo_ready;
  logic [7:0] fifo_data;
  logic tx_busy;
  logic tx_enable;
  logic sel_match;
  logic [1:0] cmd_op;

  assign rst_all = rst | sw_reset;
  assign cmd_op = cmd_q.ctrl[uart_slave_pkg::CTRL_OP_LSB +: 2];
  assign sel_match = (cmd_q.ctrl[uart_slave_pkg::CTRL_SEL_HI] == chip_addr_pin_hi) &&
                     (cmd_q.ctrl[uart_slave_pkg::CTRL_SEL_LO] == chip_addr_pin_lo);
  // the host owns the line while a character is arriving
  assign tx_enable = (rx_st_q == RX_IDLE) && rx_in;

  // ***********************************************
  // character receiver with bit period measurement
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
    begin
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_prev_q <= rx_in;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
    begin
      rx_st_q <= RX_IDLE;
      bit_per_q <= '1;
      rx_cnt_q <= '0;
      rx_idx_q <= uart_slave_pkg::CHAR_START_IDX;
      rx_sh_q <= '0;
      byte_stb_q <= 1'b0;
      byte_ok_q <= 1'b0;
      byte_q <= '0;
    end
    else
    begin
      byte_stb_q <= 1'b0;
      case (rx_st_q)
        RX_IDLE:
        begin
          if (rx_prev_q && !rx_in)
          begin
            if (frame_cnt_q == uart_slave_pkg::FRAME_HEAD_IDX)
            begin
              // header lsb is one, so its start bit is exactly one bit long
              rx_st_q <= RX_MEAS;
              rx_cnt_q <= BW'(1);
            end
            else
            begin
              rx_st_q <= RX_BITS;
              rx_idx_q <= uart_slave_pkg::CHAR_START_IDX;
              rx_cnt_q <= bit_per_q >> 1;
            end
          end
        end
        RX_MEAS:
        begin
          if (rx_in)
          begin
            bit_per_q <= rx_cnt_q;
            rx_cnt_q <= rx_cnt_q >> 1;
            rx_idx_q <= uart_slave_pkg::CHAR_DATA_IDX;
            rx_st_q <= RX_BITS;
          end
          else if (rx_cnt_q != '1)
          begin
            // saturates on a line held low; the frame is then dropped by the header check
            rx_cnt_q <= rx_cnt_q + 1'b1;
          end
        end
        RX_BITS:
        begin
          if (rx_cnt_q != '0)
          begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end
          else
          begin
            rx_cnt_q <= bit_per_q - 1'b1;
            rx_idx_q <= rx_idx_q + 1'b1;
            if (rx_idx_q == uart_slave_pkg::CHAR_START_IDX)
            begin
              if (rx_in)
              begin
                // start bit gone at mid-bit: a glitch, not a character
                rx_st_q <= RX_IDLE;
              end
            end
            else if (rx_idx_q == uart_slave_pkg::CHAR_STOP_IDX)
            begin
              byte_stb_q <= 1'b1;
              byte_q <= rx_sh_q[7:0];
              byte_ok_q <= rx_in && (^rx_sh_q);
              rx_st_q <= RX_IDLE;
            end
            else
            begin
              rx_sh_q <= {rx_in, rx_sh_q[8:1]};
            end
          end
        end
        default:
        begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ***********************************************
  // command frame assembly and checking
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
    begin
      frame_cnt_q <= uart_slave_pkg::FRAME_HEAD_IDX;
      cmd_q <= '0;
      sum_q <= '0;
      gap_q <= '0;
      cmd_go_q <= 1'b0;
    end
    else
    begin
      cmd_go_q <= 1'b0;
      if (byte_stb_q)
      begin
        gap_q <= '0;
        if (!byte_ok_q || ((frame_cnt_q == uart_slave_pkg::FRAME_HEAD_IDX) &&
            (byte_q != uart_slave_pkg::HEADER_BYTE)))
        begin
          frame_cnt_q <= uart_slave_pkg::FRAME_HEAD_IDX;
        end
        else if (frame_cnt_q == uart_slave_pkg::FRAME_CHECK_IDX)
        begin
          frame_cnt_q <= uart_slave_pkg::FRAME_HEAD_IDX;
          // a frame that completes while a reply is still pending is dropped
          cmd_go_q <= (byte_q == uart_slave_pkg::csum_final(sum_q)) &&
                      (sq_q == SQ_IDLE);
        end
        else
        begin
          frame_cnt_q <= frame_cnt_q + 1'b1;
          sum_q <= (frame_cnt_q == uart_slave_pkg::FRAME_HEAD_IDX) ?
                   byte_q : 8'(sum_q + byte_q);
          if (frame_cnt_q == uart_slave_pkg::FRAME_CTRL_IDX)
          begin
            cmd_q.ctrl <= byte_q;
          end
          else if (frame_cnt_q == uart_slave_pkg::FRAME_ADDR_IDX)
          begin
            cmd_q.addr <= byte_q;
          end
          else if (frame_cnt_q != uart_slave_pkg::FRAME_HEAD_IDX)
          begin
            cmd_q.data <= {byte_q, cmd_q.data[31:8]};
          end
        end
      end
      else if ((frame_cnt_q != uart_slave_pkg::FRAME_HEAD_IDX) && (rx_st_q == RX_IDLE))
      begin
        if (gap_q == GW'(RX_TIMEOUT_CYC - 1))
        begin
          frame_cnt_q <= uart_slave_pkg::FRAME_HEAD_IDX;
          gap_q <= '0;
        end
        else
        begin
          gap_q <= gap_q + 1'b1;
        end
      end
    end
  end

  // ***********************************************
  // reply sequencer and register requests
  // ***********************************************
  always_comb
  begin
    push_valid = 1'b0;
    push_data = '0;
    case (sq_q)
      SQ_HEAD:
      begin
        push_valid = 1'b1;
        push_data = uart_slave_pkg::HEADER_BYTE;
      end
      SQ_CTRL:
      begin
        push_valid = 1'b1;
        push_data = cmd_q.ctrl;
      end
      SQ_THIRD:
      begin
        push_valid = 1'b1;
        push_data = is_read_q ? words_q : cmd_q.addr;
      end
      SQ_DATA:
      begin
        push_valid = 1'b1;
        push_data = rdbuf_q[7:0];
      end
      SQ_SUM:
      begin
        push_valid = 1'b1;
        push_data = uart_slave_pkg::csum_final(tsum_q);
      end
      default:
      begin
        push_valid = 1'b0;
        push_data = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
    begin
      sq_q <= SQ_IDLE;
      dly_q <= '0;
      words_q <= '0;
      rd_addr_q <= '0;
      rdbuf_q <= '0;
      bytes_q <= '0;
      tsum_q <= '0;
      is_read_q <= 1'b0;
      reg_req_q <= '0;
    end
    else
    begin
      reg_req_q.wr <= 1'b0;
      reg_req_q.rd <= 1'b0;
      case (sq_q)
        SQ_IDLE:
        begin
          dly_q <= '0;
          tsum_q <= '0;
          if (cmd_go_q)
          begin
            // fields move only together with a pulse, so the register side sees them hold
            if (cmd_op == uart_slave_pkg::OP_BCAST)
            begin
              reg_req_q.addr <= {cmd_q.ctrl[uart_slave_pkg::CTRL_AHI_LSB +: 4], cmd_q.addr};
              reg_req_q.wdata <= cmd_q.data;
              reg_req_q.wr <= 1'b1;
            end
            else if ((cmd_op == uart_slave_pkg::OP_WRITE) && sel_match)
            begin
              reg_req_q.addr <= {cmd_q.ctrl[uart_slave_pkg::CTRL_AHI_LSB +: 4], cmd_q.addr};
              reg_req_q.wdata <= cmd_q.data;
              reg_req_q.wr <= 1'b1;
              is_read_q <= 1'b0;
              sq_q <= SQ_DELAY;
            end
            else if ((cmd_op == uart_slave_pkg::OP_READ) && sel_match)
            begin
              is_read_q <= 1'b1;
              words_q <= (cmd_q.data[7:0] == '0) ? uart_slave_pkg::WORDS_ONE :
                         cmd_q.data[7:0];
              rd_addr_q <= {cmd_q.ctrl[uart_slave_pkg::CTRL_AHI_LSB +: 4], cmd_q.addr};
              sq_q <= SQ_DELAY;
            end
          end
        end
        SQ_DELAY:
        begin
          if (dly_q == GW'(REPLY_DELAY_CYC - 1))
          begin
            sq_q <= SQ_HEAD;
          end
          else
          begin
            dly_q <= dly_q + 1'b1;
          end
        end
        SQ_HEAD, SQ_CTRL, SQ_THIRD, SQ_DATA, SQ_SUM:
        begin
          if (push_ready)
          begin
            tsum_q <= 8'(tsum_q + push_data);
            case (sq_q)
              SQ_HEAD:
              begin
                sq_q <= SQ_CTRL;
              end
              SQ_CTRL:
              begin
                sq_q <= SQ_THIRD;
              end
              SQ_THIRD:
              begin
                sq_q <= is_read_q ? SQ_RD : SQ_SUM;
              end
              SQ_DATA:
              begin
                rdbuf_q <= {8'h00, rdbuf_q[31:8]};
                bytes_q <= bytes_q + 1'b1;
                if (bytes_q == uart_slave_pkg::LAST_BYTE_OF_WORD)
                begin
                  words_q <= words_q - 1'b1;
                  rd_addr_q <= rd_addr_q + 1'b1;
                  sq_q <= (words_q == uart_slave_pkg::WORDS_ONE) ? SQ_SUM : SQ_RD;
                end
              end
              default:
              begin
                sq_q <= SQ_DRAIN;
              end
            endcase
          end
        end
        SQ_RD:
        begin
          reg_req_q.rd <= 1'b1;
          reg_req_q.addr <= rd_addr_q;
          sq_q <= SQ_RDW;
        end
        SQ_RDW:
        begin
          sq_q <= SQ_RDL;
        end
        SQ_RDL:
        begin
          rdbuf_q <= reg_rdata;
          bytes_q <= '0;
          sq_q <= SQ_DATA;
        end
        SQ_DRAIN:
        begin
          // new commands are held off until the last stop bit has left
          if (!fifo_valid && !tx_busy)
          begin
            sq_q <= SQ_IDLE;
          end
        end
        default:
        begin
          sq_q <= SQ_IDLE;
        end
      endcase
    end
  end

  // ***********************************************
  // reply path: fifo and transmitter
  // ***********************************************
  // reading one register costs three cycles, far below a character time,
  // so the fifo never runs dry mid-reply and characters go back to back
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_reply_fifo (
    .sys_clk(sys_clk),
    .rst(rst_all),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  uart_char_tx u_char_tx (
    .sys_clk(sys_clk),
    .rst(rst_all),
    .bit_period(bit_per_q),
    .enable(tx_enable),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_data),
    .tx_out(tx_out),
    .busy(tx_busy)
  );

endmodule // uart_register_access_slave

// file: core/uart_slave_pkg.sv
// holds constants, field positions and carrier types of the serial register access slave
// assumes a single 40 MHz system clock shared by every design file
package uart_slave_pkg;

  // ***********************************************
  // clock and timing
  // ***********************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int RX_INTERBYTE_TIMEOUT_MS = 20;
  localparam int REPLY_TURNAROUND_DELAY_MS = 1;
  // longest time rounds down
  localparam int RX_INTERBYTE_TIMEOUT_CYC = (CLK_HZ / 1000) * RX_INTERBYTE_TIMEOUT_MS;
  // least time rounds up
  localparam int REPLY_TURNAROUND_DELAY_CYC = (CLK_HZ * REPLY_TURNAROUND_DELAY_MS + 999) / 1000;
  localparam int BIT_CNT_W = 16;
  localparam int GAP_CNT_W = 24;

  // ***********************************************
  // character layout
  // ***********************************************
  localparam logic [3:0] CHAR_START_IDX = 4'h0;
  localparam logic [3:0] CHAR_DATA_IDX = 4'h1;
  localparam logic [3:0] CHAR_STOP_IDX = 4'hA;

  // ***********************************************
  // frame layout
  // ***********************************************
  localparam logic [7:0] HEADER_BYTE = 8'h7D;
  localparam logic [7:0] CSUM_BIAS = 8'h33;
  localparam logic [3:0] FRAME_HEAD_IDX = 4'h0;
  localparam logic [3:0] FRAME_CTRL_IDX = 4'h1;
  localparam logic [3:0] FRAME_ADDR_IDX = 4'h2;
  localparam logic [3:0] FRAME_CHECK_IDX = 4'h7;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_BCAST = 2'h0;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SEL_LO = 2;
  localparam int CTRL_SEL_HI = 3;
  localparam int CTRL_AHI_LSB = 4;
  localparam logic [7:0] WORDS_ONE = 8'h01;
  localparam logic [1:0] LAST_BYTE_OF_WORD = 2'h3;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic [31:0] data;
  } cmd_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // closing step of the check byte: invert the running sum, then add the bias
  function automatic logic [7:0] csum_final(input logic [7:0] sum);
    csum_final = 8'(~sum + CSUM_BIAS);
  endfunction

endpackage

// file: testbench/host_uart_model.sv
// host side of the serial link: sends and receives 11-bit characters
// assumes one clock; the bench calls the tasks
`timescale 1ns/1ps
module host_uart_model #(
  parameter int BIT_CYC = 40
) (
  input wire logic sys_clk, // clock
  input wire logic tx_out, // device reply line
  output logic rx_line // command line, idle high
);
  // ****************************
  // character tasks
  // ****************************
  initial rx_line = 1'b1;
  task automatic send_byte(input logic [7:0] b, input logic bad_par);
    logic [10:0] ch;
    ch = {1'b1, ~^b ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge sys_clk);
      rx_line <= ch[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
  endtask
  // samples at mid bit on the falling clock edge to stay clear of updates
  task automatic recv_byte(input int lim, output logic [7:0] b, output logic ok);
    logic [10:0] ch;
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (tx_out !== 1'b0 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (tx_out === 1'b0)
    begin
      repeat (BIT_CYC / 2) @(negedge sys_clk);
      for (int i = 0; i < 11; i++)
      begin
        ch[i] = tx_out;
        if (i < 10)
          repeat (BIT_CYC) @(negedge sys_clk);
      end
      b = ch[8:1];
      ok = ch[0] === 1'b0 && ch[10] === 1'b1 && ^ch[9:1] === 1'b1;
    end
  endtask
endmodule // host_uart_model

// file: testbench/tb_uart_register_access_slave.sv
// self-checking bench for the serial register access slave
// assumes a fast host baud of 40 clocks per bit and shortened delays
`timescale 1ns/1ps
module tb_uart_register_access_slave;
  localparam int BIT_CYC = 40;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sw_reset = 1'b0;
  logic chip_addr_pin_hi = 1'b0;
  logic chip_addr_pin_lo = 1'b0;
  logic rx_in, tx_out, tx_prev;
  logic [31:0] reg_rdata;
  uart_slave_pkg::reg_req_t req;
  int error_cnt = 0, compares = 0, wr_cnt = 0, rd_cnt = 0, tx_falls = 0;
  logic [7:0] exp_q[$];
  always #12.5 sys_clk = ~sys_clk;
  host_uart_model #(.BIT_CYC(BIT_CYC)) host (.sys_clk(sys_clk), .tx_out(tx_out),
    .rx_line(rx_in));
  uart_register_access_slave #(.RX_TIMEOUT_CYC(2000), .REPLY_DELAY_CYC(50),
    .FIFO_DEPTH(4)) dut (.sys_clk(sys_clk), .rst(rst), .sw_reset(sw_reset),
    .rx_in(rx_in), .chip_addr_pin_hi(chip_addr_pin_hi),
    .chip_addr_pin_lo(chip_addr_pin_lo), .reg_rdata(reg_rdata),
    .tx_out(tx_out), .reg_req_q(req));
  // ****************************
  // register file and monitors
  // ****************************
  function automatic logic [31:0] word_at(input logic [11:0] a);
    return {4'hA, a, 4'h5, ~a};
  endfunction
  assign reg_rdata = word_at(req.addr);
  always @(negedge sys_clk)
  begin
    tx_prev <= tx_out;
    if (req.wr === 1'b1) wr_cnt++;
    if (req.rd === 1'b1) rd_cnt++;
    if (tx_prev === 1'b1 && tx_out === 1'b0) tx_falls++;
  end
  // ****************************
  // helpers
  // ****************************
  function automatic logic [7:0] csum(input logic [7:0] q[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s += q[i];
    return 8'(~s + 8'h33);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send_frame(input logic [7:0] c, a, input logic [31:0] d, input logic [7:0] bad,
    input logic bp);
    logic [7:0] f[$];
    f = {8'h7D, c, a, d[7:0], d[15:8], d[23:16], d[31:24]};
    f.push_back(csum(f) ^ bad);
    foreach (f[i]) host.send_byte(f[i], bp && i == 7);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************
  // scenarios
  // ****************************
  initial
  begin
    logic [7:0] c, a, nw, b;
    logic [1:0] p, op, sel;
    logic [31:0] d, w;
    logic good, ok;
    int w0, r0, f0;
    void'($urandom(81));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int t = 0; t < 11; t++)
    begin
      p = 2'($urandom);
      op = t == 10 ? 2'h3 : t == 4 ? uart_slave_pkg::OP_BCAST : (t == 2 || t == 3) ?
        uart_slave_pkg::OP_READ : uart_slave_pkg::OP_WRITE;
      sel = (t == 4 || t == 5) ? ~p : p;
      c = {4'($urandom), sel, op};
      a = 8'($urandom);
      d = $urandom;
      if (op == uart_slave_pkg::OP_READ) d[7:0] = t == 2 ? 8'h00 : 8'h03;
      nw = d[7:0] == 8'h00 ? 8'h01 : d[7:0];
      @(posedge sys_clk);
      {chip_addr_pin_hi, chip_addr_pin_lo} <= p;
      w0 = wr_cnt;
      r0 = rd_cnt;
      f0 = tx_falls;
      if (t == 7 || t == 8)
        for (int i = 0; i < 3; i++) host.send_byte(i == 0 ? 8'h7D : c, 1'b0);
      if (t == 7) repeat (2500) @(posedge sys_clk);
      if (t == 8)
      begin
        @(posedge sys_clk);
        sw_reset <= 1'b1;
        @(posedge sys_clk);
        sw_reset <= 1'b0;
      end
      send_frame(c, a, d, t == 6 ? 8'h01 : 8'h00, t == 9);
      good = t != 5 && t != 6 && t < 9;
      if (good && op != uart_slave_pkg::OP_BCAST)
      begin
        exp_q = {8'h7D, c, op == uart_slave_pkg::OP_WRITE ? a : nw};
        for (int i = 0; op == uart_slave_pkg::OP_READ && i < nw; i++)
        begin
          w = word_at(12'({c[7:4], a} + i));
          exp_q = {exp_q, w[7:0], w[15:8], w[23:16], w[31:24]};
        end
        exp_q.push_back(csum(exp_q));
        foreach (exp_q[i])
        begin
          host.recv_byte(i == 0 ? 200 : 4 * BIT_CYC, b, ok);
          check("reply framing", 32'(ok), 32'h1);
          check("reply byte", 32'(exp_q[i]), 32'(b));
        end
      end
      else
      begin
        repeat (400) @(posedge sys_clk);
        check("silent line", 32'(tx_falls - f0), 32'h0);
      end
      check("write count", 32'(wr_cnt - w0), 32'(good && op != uart_slave_pkg::OP_READ));
      if (good && op != uart_slave_pkg::OP_READ)
      begin
        check("write addr", 32'(req.addr), 32'({c[7:4], a}));
        check("write data", req.wdata, d);
      end
      check("read count", 32'(rd_cnt - r0), good && op == uart_slave_pkg::OP_READ ? 32'(nw) : 0);
      repeat (100) @(posedge sys_clk);
      $display("case %0d done", t);
    end
    complete_run();
  end
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end
endmodule // tb_uart_register_access_slave

// file: testbench/uart_slave_assertions.sv
// concurrent checks on the serial slave's ports
// assumes it is bound into the slave top module
`timescale 1ns/1ps
module uart_slave_checker #(
  parameter int REPLY_DELAY_CYC = 50
) (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic sw_reset, // soft reset
  input wire logic rx_in, // host line
  input wire logic tx_out, // reply line
  input wire uart_slave_pkg::reg_req_t reg_req_q // requests
);
  // ****************************
  // line quiet time
  // ****************************
  logic [15:0] quiet_q;
  // saturates so a long idle never wraps to a small value
  always_ff @(posedge sys_clk)
  begin
    if (rst || !rx_in)
      quiet_q <= 16'h0000;
    else if (quiet_q != 16'hFFFF)
      quiet_q <= quiet_q + 16'h0001;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rst_idle_out: assert property ($past(rst) |-> tx_out && reg_req_q == '0)
    else $error("outputs busy after reset");
  a_swrst_idle_out: assert property (sw_reset |=> tx_out && reg_req_q == '0)
    else $error("outputs busy after soft reset");
  a_wr_single_pulse: assert property (reg_req_q.wr |=> !reg_req_q.wr)
    else $error("write pulse too long");
  a_rd_single_pulse: assert property (reg_req_q.rd |=> !reg_req_q.rd && !reg_req_q.wr)
    else $error("read pulse too long");
  a_req_fields_hold: assert property (!reg_req_q.wr && !reg_req_q.rd && !$past(sw_reset) |->
    $stable(reg_req_q.addr) && $stable(reg_req_q.wdata))
    else $error("request fields moved");
  a_wr_after_stop: assert property (reg_req_q.wr |-> quiet_q >= 16'h0003)
    else $error("write before frame end");
  a_reply_turnaround: assert property ($fell(tx_out) |-> int'(quiet_q) >= REPLY_DELAY_CYC)
    else $error("reply too early");
  a_half_duplex_tx: assert property ($fell(tx_out) |-> $past(rx_in, 2) && rx_in)
    else $error("transmit while host sends");
endmodule // uart_slave_checker

bind uart_register_access_slave uart_slave_checker #(
  .REPLY_DELAY_CYC(REPLY_DELAY_CYC)
) chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .sw_reset(sw_reset),
  .rx_in(rx_in),
  .tx_out(tx_out),
  .reg_req_q(reg_req_q)
);
